// ===== logic/sap_top.sv
// Functional notes
// - The node address is ten times the tens switch plus the units switch.
// - The delivered switch setting and the address held before the pins settle is eleven.
// - Addresses one to thirty-nine select automatic protocol recognition.
// - In that range the frame is fixed at 8 data bits, even parity, one stop, rate detected.
// - Addresses forty to fifty-nine select RTU with software-set rate and frame, 9600 8n1.
// - A change of the switches takes effect at once without a restart.
// - Addresses 99, 98 and 97 at power-on request factory reset, boot erase, config erase.
// - Start-up runs state check, terminal bus set-up, module list, then PLC start.
// - The I/O LED flashes during start-up and stops after about two to three seconds.
// - On a fault the flashing LED is chosen by the type of error.
// - After power-on the link rate is searched once and kept while powered.
// - Detection is never repeated until the next power cycle.
// - RTU rates are 1200 to 38400 in six steps; parity is even, odd or none.
module sap_top
	import sap_pkg::*;
#(
	parameter int STARTUP_CYCLES = STARTUP_CYC,
	parameter int BLINK_CYCLES   = BLINK_CYC
)(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// pins
	input  wire logic [3:0]  tens_rotary_switch,
	input  wire logic [3:0]  units_rotary_switch,
	input  wire logic        rxd,
	// start-up step handshake from local logic
	input  wire logic        step_done,
	input  wire logic        step_fault,
	input  wire logic [1:0]  fault_code,
	// serial configuration, start-up step and special request out
	output logic [1:0]       proto_mode,
	output logic [2:0]       baud_sel,
	output logic [1:0]       parity_sel,
	output logic [2:0]       startup_step,
	output logic [2:0]       special_req,
	// indicators and interrupt
	output logic             io_led,
	output logic [3:0]       fault_led,
	output logic             irq
);
	localparam int SYNC_W = 9;
	localparam logic [31:0] STARTUP_LAST = 32'(STARTUP_CYCLES - 1);
	localparam logic [31:0] BLINK_LAST   = 32'(BLINK_CYCLES - 1);

	// three-stage pin sync; value updates only when stages two and three agree
	logic [SYNC_W-1:0] s1;
	logic [SYNC_W-1:0] s2;
	logic [SYNC_W-1:0] s3;
	logic [SYNC_W-1:0] pin;
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					s1[g]  <= 1'b1;
					s2[g]  <= 1'b1;
					s3[g]  <= 1'b1;
					pin[g] <= 1'b1;
				end else begin
					s1[g] <= g == 8 ? rxd : (g < 4 ? units_rotary_switch[g % 4]
					                               : tens_rotary_switch[g % 4]);
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g]) begin
						pin[g] <= s3[g];
					end
				end
			end
		end
	endgenerate

	logic [3:0] units_d;
	logic [3:0] tens_d;
	logic       rxd_f;
	assign units_d = pin[3:0];
	assign tens_d  = pin[7:4];
	assign rxd_f   = pin[8];

	// settle counter: switches are trusted only after the sync chain filled
	logic [3:0] settle;
	logic       settled;
	assign settled = int'(settle) >= SETTLE_CYC;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settle <= '0;
		end else if (!settled) begin
			settle <= settle + 1'b1;
		end
	end

	// node_addr lags settle by one edge; judging it earlier would see the reset value
	logic addr_live;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_live <= 1'b0;
		end else begin
			addr_live <= settled;
		end
	end

	// live node address, follows the switches every cycle
	logic [6:0] node_addr;
	logic       digits_ok;
	assign digits_ok = tens_d <= DIGIT_MAX && units_d <= DIGIT_MAX;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			node_addr <= ADDR_DEFAULT;
		end else if (settled) begin
			node_addr <= 7'({tens_d, 3'b000}) + 7'({tens_d, 1'b0}) + 7'(units_d);
		end
	end

	// mode decode; reserved addresses only act at power-on, so run as invalid
	sap_mode_t mode;
	always_comb begin
		mode = MODE_OFF;
		if (digits_ok && node_addr >= ADDR_AUTO_LO && node_addr <= ADDR_AUTO_HI) begin
			mode = MODE_AUTO;
		end else if (digits_ok && node_addr >= ADDR_RTU_LO && node_addr <= ADDR_RTU_HI) begin
			mode = MODE_RTU;
		end
	end

	// baud detection runs only once per power-on
	logic [2:0] det_idx;
	logic       det_locked;
	sap_baud_detect u_baud (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.rxd       (rxd_f),
		.detect_en (settled),
		.baud_idx  (det_idx),
		.locked    (det_locked)
	);

	// software-set rtu format
	logic [2:0] rtu_baud;
	logic [1:0] rtu_par;

	// serial configuration outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			proto_mode <= MODE_OFF;
			baud_sel   <= BAUD_IDX_38400;
			parity_sel <= PAR_EVEN;
		end else begin
			proto_mode <= mode;
			case (mode)
				MODE_AUTO: begin
					baud_sel   <= det_idx;
					parity_sel <= PAR_EVEN;
				end
				MODE_RTU: begin
					baud_sel   <= rtu_baud;
					parity_sel <= rtu_par;
				end
				default: begin
					baud_sel   <= baud_sel;
					parity_sel <= parity_sel;
				end
			endcase
		end
	end

	// start-up sequencer
	sap_state_t state;
	logic [31:0] elapsed;
	logic        start_done;
	logic        special_hit;
	assign special_hit = node_addr == ADDR_FACTORY || node_addr == ADDR_DEL_BOOT
	                  || node_addr == ADDR_DEL_CONFIG;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state       <= ST_CHECK;
			special_req <= 3'h0;
		end else begin
			case (state)
				ST_CHECK: begin
					// address checked every cycle while in ST_CHECK, from the second edge after the pins settle
					if (addr_live && special_hit) begin
						state       <= ST_SPECIAL;
						special_req <= {node_addr == ADDR_FACTORY, node_addr == ADDR_DEL_BOOT,
						                node_addr == ADDR_DEL_CONFIG};
					end else if (step_fault) begin
						state <= ST_FAULT;
					end else if (addr_live && step_done) begin
						state <= ST_KBUS;
					end
				end
				ST_KBUS, ST_LIST, ST_PLC: begin
					if (step_fault) begin
						state <= ST_FAULT;
					end else if (step_done) begin
						state <= sap_state_t'(state + 3'h1);
					end
				end
				ST_RUN: begin
					if (step_fault) begin
						state <= ST_FAULT;
					end
				end
				ST_SPECIAL, ST_FAULT: begin
					state <= state;
				end
				default: begin
					state <= ST_FAULT;
				end
			endcase
		end
	end

	// flashing stops only once the sequence ran clean and the minimum time passed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			elapsed    <= '0;
			start_done <= 1'b0;
		end else begin
			if (elapsed != STARTUP_LAST) begin
				elapsed <= elapsed + 1'b1;
			end
			if (state == ST_RUN && elapsed == STARTUP_LAST) begin
				start_done <= 1'b1;
			end else if (state == ST_FAULT) begin
				start_done <= 1'b0;
			end
		end
	end

	// blink timebase
	logic [31:0] blink_cnt;
	logic        blink;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blink_cnt <= '0;
			blink     <= 1'b1;
		end else if (blink_cnt == BLINK_LAST) begin
			blink_cnt <= '0;
			blink     <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	// indicators
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			io_led       <= 1'b0;
			fault_led    <= 4'h0;
			startup_step <= ST_CHECK;
		end else begin
			startup_step <= state;
			if (state == ST_FAULT) begin
				io_led    <= 1'b0;
				fault_led <= blink ? 4'h1 << fault_code : 4'h0;
			end else begin
				io_led    <= start_done ? 1'b1 : blink;
				fault_led <= 4'h0;
			end
		end
	end

	// interrupt events
	logic [IRQ_N-1:0] ev;
	logic             lock_q;
	logic             done_q;
	logic             fault_q;
	logic [6:0]       addr_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_q  <= 1'b0;
			done_q  <= 1'b0;
			fault_q <= 1'b0;
			addr_q  <= ADDR_DEFAULT;
		end else begin
			lock_q  <= det_locked;
			done_q  <= start_done;
			fault_q <= state == ST_FAULT;
			addr_q  <= node_addr;
		end
	end
	always_comb begin
		ev                 = '0;
		ev[IRQ_BAUD_LOCK]  = det_locked && !lock_q;
		ev[IRQ_ADDR_CHG]   = node_addr != addr_q;
		ev[IRQ_START_DONE] = start_done && !done_q;
		ev[IRQ_FAULT]      = state == ST_FAULT && !fault_q;
	end

	// ahb-lite: zero wait state, address captured, write in data phase
	logic       dp_write;
	logic [7:0] dp_addr;
	logic       take;
	assign take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write  <= 1'b0;
			dp_addr   <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			dp_write <= take && hwrite;
			if (take) begin
				dp_addr <= haddr[7:0];
			end
		end
	end

	logic [IRQ_N-1:0] irq_st;
	logic [IRQ_N-1:0] irq_en;
	logic [IRQ_N-1:0] irq_clr;
	assign irq_clr = dp_write && dp_addr == REG_IRQ_CLR ? hwdata[IRQ_N-1:0] : '0;

	// control and interrupt registers; a new event beats a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rtu_baud <= BAUD_IDX_9600;
			rtu_par  <= PAR_NONE;
			irq_en   <= '0;
			irq_st   <= '0;
			irq      <= 1'b0;
		end else begin
			if (dp_write && dp_addr == REG_CTRL) begin
				// out-of-table rate or parity codes are refused, old value kept
				if (int'(hwdata[CTRL_BAUD_LSB +: 3]) < BAUD_N) begin
					rtu_baud <= hwdata[CTRL_BAUD_LSB +: 3];
				end
				if (hwdata[CTRL_PAR_LSB +: 2] != 2'h3) begin
					rtu_par <= hwdata[CTRL_PAR_LSB +: 2];
				end
			end
			if (dp_write && dp_addr == REG_IRQ_EN) begin
				irq_en <= hwdata[IRQ_N-1:0];
			end
			irq_st <= (irq_st & ~irq_clr) | ev;
			irq    <= |(((irq_st & ~irq_clr) | ev) & irq_en);
		end
	end

	// read mux sampled at the address phase
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		case (haddr[7:0])
			REG_CTRL: begin
				rd[CTRL_BAUD_LSB +: 3] = rtu_baud;
				rd[CTRL_PAR_LSB +: 2]  = rtu_par;
			end
			REG_STATUS: begin
				rd[ST_ADDR_LSB +: 7]  = node_addr;
				rd[ST_MODE_LSB +: 2]  = mode;
				rd[ST_BAUD_LSB +: 3]  = det_idx;
				rd[ST_LOCK_BIT]       = det_locked;
				rd[ST_STATE_LSB +: 3] = state;
				rd[ST_DONE_BIT]       = start_done;
				rd[ST_PAR_LSB +: 2]   = parity_sel;
			end
			REG_IRQ_ST: rd[IRQ_N-1:0] = irq_st;
			REG_IRQ_EN: rd[IRQ_N-1:0] = irq_en;
			default:    rd = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= rd;
		end
	end
endmodule

// ===== logic/sap_pkg.sv
package sap_pkg;
	// clock and timing
	localparam int CLK_HZ       = 20_000_000;
	localparam int STARTUP_MS   = 2500;
	localparam int BLINK_MS     = 250;
	localparam int STARTUP_CYC  = CLK_HZ / 1000 * STARTUP_MS;
	localparam int BLINK_CYC    = CLK_HZ / 1000 * BLINK_MS;
	localparam int SETTLE_CYC   = 8;

	// node address ranges and reserved addresses
	localparam logic [6:0] ADDR_DEFAULT    = 7'h0B;
	localparam logic [6:0] ADDR_AUTO_LO    = 7'h01;
	localparam logic [6:0] ADDR_AUTO_HI    = 7'h27;
	localparam logic [6:0] ADDR_RTU_LO     = 7'h28;
	localparam logic [6:0] ADDR_RTU_HI     = 7'h3B;
	localparam logic [6:0] ADDR_FACTORY    = 7'h63;
	localparam logic [6:0] ADDR_DEL_BOOT   = 7'h62;
	localparam logic [6:0] ADDR_DEL_CONFIG = 7'h61;
	localparam logic [3:0] DIGIT_MAX       = 4'h9;

	// baud table, index 0..5
	localparam int BAUD_N = 6;
	localparam int BAUD_RATE [BAUD_N] = '{1200, 2400, 4800, 9600, 19200, 38400};
	localparam logic [2:0] BAUD_IDX_9600  = 3'h3;
	localparam logic [2:0] BAUD_IDX_38400 = 3'h5;
	localparam int MEAS_W     = 16;
	localparam int MIN_PULSE  = CLK_HZ / 38400 / 2;
	localparam int DETECT_PULSES = 4;

	// parity codes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h1;
	localparam logic [1:0] PAR_ODD  = 2'h2;

	typedef enum logic [1:0] {
		MODE_OFF  = 2'b00,
		MODE_AUTO = 2'b01,
		MODE_RTU  = 2'b10
	} sap_mode_t;

	typedef enum logic [2:0] {
		ST_CHECK   = 3'b000,
		ST_KBUS    = 3'b001,
		ST_LIST    = 3'b010,
		ST_PLC     = 3'b011,
		ST_RUN     = 3'b100,
		ST_SPECIAL = 3'b101,
		ST_FAULT   = 3'b110
	} sap_state_t;

	// register map (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_IRQ_ST  = 8'h08;
	localparam logic [7:0] REG_IRQ_EN  = 8'h0C;
	localparam logic [7:0] REG_IRQ_CLR = 8'h10;

	// field positions
	localparam int CTRL_BAUD_LSB = 0;
	localparam int CTRL_PAR_LSB  = 4;
	localparam int ST_ADDR_LSB   = 0;
	localparam int ST_MODE_LSB   = 8;
	localparam int ST_BAUD_LSB   = 12;
	localparam int ST_LOCK_BIT   = 15;
	localparam int ST_STATE_LSB  = 16;
	localparam int ST_DONE_BIT   = 19;
	localparam int ST_PAR_LSB    = 20;

	// interrupt events
	localparam int IRQ_N          = 4;
	localparam int IRQ_BAUD_LOCK  = 0;
	localparam int IRQ_ADDR_CHG   = 1;
	localparam int IRQ_START_DONE = 2;
	localparam int IRQ_FAULT      = 3;
endpackage

// ===== logic/sap_baud_detect.sv
// measures the shortest low pulse after power-on and locks the nearest rate
module sap_baud_detect
	import sap_pkg::*;
(
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// filtered receive line and enable
	input  wire logic       rxd,
	input  wire logic       detect_en,
	// result
	output logic [2:0]      baud_idx,
	output logic            locked
);
	localparam logic [MEAS_W-1:0] MEAS_MAX = '1;
	localparam logic [MEAS_W-1:0] MIN_LEN  = MEAS_W'(MIN_PULSE);

	logic              rxd_q;
	logic [MEAS_W-1:0] meas;
	logic [MEAS_W-1:0] shortest;
	logic [2:0]        pulses;
	logic [2:0]        next_idx;

	// nearest rate: compare against midpoints between adjacent bit times
	always_comb begin
		next_idx = 3'h0;
		for (int k = 0; k < BAUD_N - 1; k++) begin
			if (int'(shortest) < (CLK_HZ / BAUD_RATE[k] + CLK_HZ / BAUD_RATE[k+1]) / 2) begin
				next_idx = 3'(k + 1);
			end
		end
	end

	// pulse width counter, saturates so a stuck line cannot wrap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxd_q <= 1'b1;
			meas  <= '0;
		end else begin
			rxd_q <= rxd;
			if (!rxd && rxd_q) begin
				meas <= '0;
			end else if (!rxd && meas != MEAS_MAX) begin
				meas <= meas + 1'b1;
			end
		end
	end

	// one detection per power-on; nothing reopens it short of reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shortest <= '1;
			pulses   <= '0;
			locked   <= 1'b0;
			baud_idx <= BAUD_IDX_38400;
		end else if (!locked && detect_en) begin
			if (rxd && !rxd_q && meas >= MIN_LEN) begin
				if (meas < shortest) begin
					shortest <= meas;
				end
				pulses <= pulses + 1'b1;
			end
			if (int'(pulses) == DETECT_PULSES) begin
				locked   <= 1'b1;
				baud_idx <= next_idx;
			end
		end
	end
endmodule

// ===== tb/sap_checker.sv
module sap_checker
	import sap_pkg::*;
(
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// switch pins
	input wire logic [3:0] tens_rotary_switch,
	input wire logic [3:0] units_rotary_switch,
	// watched outputs
	input wire logic [1:0] proto_mode,
	input wire logic [2:0] baud_sel,
	input wire logic [2:0] startup_step,
	input wire logic [2:0] special_req,
	input wire logic       io_led,
	input wire logic [3:0] fault_led
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// pins pass a synchroniser, so the mode is allowed a few cycles to follow
	AST_RTU: assert property ((tens_rotary_switch inside {4'h4, 4'h5}
		&& units_rotary_switch <= DIGIT_MAX && startup_step < ST_SPECIAL)[*8]
		|-> ##[0:4] proto_mode == MODE_RTU) else $error("mode not rtu");
	AST_AUTO: assert property ((tens_rotary_switch <= 4'h3
		&& units_rotary_switch <= DIGIT_MAX
		&& {tens_rotary_switch, units_rotary_switch} != 8'h00 && startup_step < ST_SPECIAL)[*8]
		|-> ##[0:4] proto_mode == MODE_AUTO) else $error("mode not auto");
	AST_OFF: assert property ((tens_rotary_switch inside {4'h6, 4'h7, 4'h8})[*8]
		|-> ##[0:4] proto_mode == MODE_OFF) else $error("mode not off");
	// the step output trails the request by one edge
	AST_SPECIAL: assert property (special_req != 3'h0 |-> ##1 startup_step == ST_SPECIAL)
		else $error("special request outside special state");
	AST_STEP: assert property ($changed(startup_step) && $past(startup_step) < ST_RUN
		&& !(startup_step inside {ST_SPECIAL, ST_FAULT})
		|-> startup_step == $past(startup_step) + 3'h1) else $error("start-up step skipped");
	AST_LED_FAULT: assert property ((startup_step == ST_FAULT)[*2] |-> !io_led)
		else $error("io led lit in fault");
	AST_FLED: assert property (fault_led != 4'h0 |-> ##[0:1] startup_step == ST_FAULT)
		else $error("fault led without fault");
	AST_BAUD: assert property (baud_sel <= 3'h5)
		else $error("baud index out of table");
	// only valid with the short blink count; a full half period needs a counter instead
	AST_BLINK: assert property (startup_step < ST_RUN && io_led
		|-> ##[1:1000] (!io_led || startup_step >= ST_RUN))
		else $error("io led steady during start-up");
endmodule
bind sap_top sap_checker u_chk (.hclk, .hresetn, .tens_rotary_switch, .units_rotary_switch,
	.proto_mode, .baud_sel, .startup_step, .special_req, .io_led, .fault_led);

// ===== tb/sap_serial_master.sv
// serial master: sends low pulses one bit time long, as start bits do
module sap_serial_master (
	// clock
	input wire logic hclk,
	// receive line of the device, idle high
	output logic     rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rxd = 1'b1;
	// idle of three bit times keeps each low pulse isolated for the measurement
	task automatic send_pulses(input int bit_cyc, input int n);
		repeat (n) begin
			@(posedge hclk);
			rxd <= 1'b0;
			repeat (bit_cyc) @(posedge hclk);
			rxd <= 1'b1;
			repeat (3 * bit_cyc) @(posedge hclk);
		end
	endtask
endmodule

// ===== tb/sap_top_tb_top.sv
module sap_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sap_pkg::*;
	// bench-driven and observed signals
	logic        hclk, hresetn, hsel, hwrite, hready, step_done, step_fault;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans, fault_code, proto_mode, parity_sel;
	logic [2:0]  hsize, baud_sel, startup_step, special_req;
	logic [3:0]  tens, units, fault_led;
	logic        hreadyout, hresp, rxd, io_led, irq, seen0, seen1;
	int          num_errors, comparisons, i;
	assign hready = hreadyout;
	// short start-up and blink counts keep the run brief
	sap_top #(.STARTUP_CYCLES(200), .BLINK_CYCLES(10)) DUT (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.tens_rotary_switch(tens), .units_rotary_switch(units), .rxd, .step_done, .step_fault,
		.fault_code, .proto_mode, .baud_sel, .parity_sel, .startup_step, .special_req,
		.io_led, .fault_led, .irq);
	sap_serial_master u_master (.hclk, .rxd);
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	task automatic report_and_stop();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// a wait that ran out ends the run
	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			num_errors++;
			report_and_stop();
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task automatic wait_ready();
		int n;
		for (n = 0; n < 16; n++) begin
			@(posedge hclk);
			if (hready === 1'b1) break;
		end
		bound(n, 16);
	endtask
	// single word transfer; ends on the edge that closes the data phase
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask
	initial begin
		repeat (90000) @(posedge hclk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		{hsel, hwrite, step_done, step_fault} = 4'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		fault_code = 2'h0;
		tens = 4'h1;
		units = 4'h1;
		hresetn = 1'b0;
		tick(20);
		hresetn <= 1'b1;
		tick(12);
		bus(REG_STATUS, 1'b0, 32'h0);
		chk("status", 32'h0010510B, q);
		chk("bus resp", 32'h2, 32'({hreadyout, hresp}));
		chk("parity", 32'(PAR_EVEN), 32'(parity_sel));
		bus(REG_CTRL, 1'b0, 32'h0);
		chk("ctrl", 32'h00000003, q);
		bus(REG_IRQ_EN, 1'b1, 32'h00000004);
		seen0 = 1'b0;
		seen1 = 1'b0;
		for (i = 0; i < 30; i++) begin
			tick(1);
			seen0 |= (io_led === 1'b0);
			seen1 |= (io_led === 1'b1);
		end
		chk("blink", 32'h3, 32'({seen1, seen0}));
		for (i = 0; i < 4; i++) begin
			step_done <= 1'b1;
			tick(1);
			step_done <= 1'b0;
			tick(2);
			chk("step", i + 1, 32'(startup_step));
		end
		// io_led is high half the time while blinking, so wait on the done flag
		q = 32'h0;
		for (i = 0; i < 400 && q[ST_DONE_BIT] !== 1'b1; i++) bus(REG_STATUS, 1'b0, 32'h0);
		bound(i, 400);
		tick(2);
		chk("irq done", 32'h1, 32'(irq));
		seen0 = 1'b0;
		for (i = 0; i < 30; i++) begin
			tick(1);
			seen0 |= (io_led !== 1'b1);
		end
		chk("steady led", 32'h0, 32'(seen0));
		bus(REG_IRQ_ST, 1'b0, 32'h0);
		chk("irq status", 32'h4, q);
		bus(REG_IRQ_CLR, 1'b1, 32'h4);
		tick(2);
		chk("irq clear", 32'h0, 32'(irq));
		u_master.send_pulses(2083, 4);
		tick(4);
		chk("irq masked", 32'h0, 32'(irq));
		bus(REG_STATUS, 1'b0, 32'h0);
		chk("lock 9600", 32'hB, 32'(q[15:12]));
		chk("baud auto", 32'(BAUD_IDX_9600), 32'(baud_sel));
		bus(REG_IRQ_EN, 1'b1, 32'h1);
		tick(2);
		chk("irq lock", 32'h1, 32'(irq));
		bus(REG_IRQ_CLR, 1'b1, 32'h1);
		u_master.send_pulses(521, 4);
		tick(4);
		bus(REG_STATUS, 1'b0, 32'h0);
		chk("no rerun", 32'hB, 32'(q[15:12]));
		tens <= 4'h4;
		units <= 4'h5;
		tick(16);
		chk("rtu", {MODE_RTU, BAUD_IDX_9600, PAR_NONE}, {proto_mode, baud_sel, parity_sel});
		bus(REG_STATUS, 1'b0, 32'h0);
		chk("addr 45", 32'd45, 32'(q[6:0]));
		bus(REG_IRQ_ST, 1'b0, 32'h0);
		chk("addr irq", 32'h2, q & 32'h2);
		for (i = 0; i < 6; i++) begin
			bus(REG_CTRL, 1'b1, 32'(((i % 3) << 4) | i));
			tick(2);
			chk("rtu baud", i, 32'(baud_sel));
			chk("rtu parity", i % 3, 32'(parity_sel));
		end
		bus(REG_CTRL, 1'b1, 32'h00000036);
		bus(REG_CTRL, 1'b0, 32'h0);
		chk("ctrl refused", 32'h00000025, q);
		bus(8'h20, 1'b1, 32'hFFFFFFFF);
		bus(8'h20, 1'b0, 32'h0);
		chk("unmapped", 32'h0, q);
		tens <= 4'h7;
		units <= 4'h0;
		tick(16);
		chk("invalid", 32'(MODE_OFF), 32'(proto_mode));
		tens <= 4'h9;
		units <= 4'h9;
		tick(16);
		chk("late 99", {MODE_OFF, 3'h0, ST_RUN}, {proto_mode, special_req, startup_step});
		for (i = 0; i < 3; i++) begin
			hresetn <= 1'b0;
			units <= 4'(7 + i);
			tick(20);
			hresetn <= 1'b1;
			tick(20);
			chk("special", {ST_SPECIAL, 3'(1 << i)}, {startup_step, special_req});
		end
		hresetn <= 1'b0;
		tens <= 4'h1;
		units <= 4'h1;
		tick(20);
		hresetn <= 1'b1;
		tick(12);
		step_fault <= 1'b1;
		fault_code <= 2'h2;
		tick(3);
		chk("fault step", 32'(ST_FAULT), 32'(startup_step));
		for (i = 0; i < 40 && fault_led !== 4'h4; i++) tick(1);
		bound(i, 40);
		chk("fault io led", 32'h0, 32'(io_led));
		bus(REG_IRQ_ST, 1'b0, 32'h0);
		chk("irq fault", 32'h8, q);
		report_and_stop();
	end
endmodule
